/* File: hw/resolver_position_capture_regs.sv */
// resolver position capture block with axi4-lite registers
// Functional notes
// - position comes from a 12-bit converter word per electrical turn.
// - the periodic register refreshes once per programmed update period.
// - the strobe register loads the position on each strobe rising edge.
// - both position registers are read-only; writes leave them unchanged.
// - status and control content shows at two offsets, one RO, one RW.
// - the module drives the common clock only while control bit 6 is set.
// - each update period count stands for 500 microseconds.
// - status bit 15 reports common clock present; writing 64 drives it.
// - the periodic value follows shaft angle, rising clockwise.
// - with a still shaft the strobe capture equals the periodic value.
// - a 2-bit turn counter sits in the top bits, cleared by reset.
// - an optional interrupt per sample fires after the value is latched.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module resolver_position_capture_regs
   import resolver_pkg::*;
#(
   parameter int STEP_CYC = STEP_CYCLES,
   parameter int CCLK_HALF = CCLK_HALF_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [POS_BITS-1:0] converter_angle,
   input wire logic external_strobe,
   input wire logic common_clock_in,
   output logic common_clock_out,
   output logic common_clock_oe_n,
   output logic irq
);
   //////////////////////////////////////////////////////////////////////
   logic [15:0] int_control_q;
   logic [15:0] update_period_q;
   logic [15:0] periodic_pos_q;
   logic [15:0] strobe_pos_q;
   logic [1:0] turns_q;
   logic [POS_BITS-1:0] angle_prev_q;
   logic [EV_WIDTH-1:0] ev_status_q;
   logic [EV_WIDTH-1:0] ev_mask_q;
   logic strobe_s1_q, strobe_s2_q, strobe_s3_q;
   logic cc_s1_q, cc_s2_q, cc_s3_q;
   logic cclk_seen_q;
   // four half periods of the default clock need more than eight bits
   logic [9:0] cc_idle_q;
   logic [15:0] period_cnt_q;
   logic step_tick, sample_tick, strobe_rise;
   logic cclk_tick, cclk_q;
   logic period_wr;
   logic [15:0] position;

   function automatic logic [15:0] status_word(input logic [15:0] ctl,
                                               input logic seen);
      status_word = ctl;
      status_word[CCLK_SEEN_BIT] = seen;
   endfunction : status_word

   //////////////////////////////////////////////////////////////////////
   // axi4-lite write channel: address and data taken in either order
   logic aw_held_q, w_held_q;
   logic [31:0] awaddr_q, wdata_q;
   logic [3:0] wstrb_q;
   logic wr_go;

   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready = !w_held_q && !s_axi_bvalid;
   assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         // position and interrupt status offsets are read-only and answer slverr
         unique case (awaddr_q)
            OFS_INT_CONTROL, OFS_UPDATE_PERIOD, OFS_EVENT_STATUS,
            OFS_EVENT_MASK: s_axi_bresp <= RESP_OKAY;
            default: s_axi_bresp <= RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0] strb);
      merge16 = old;
      if (strb[0]) merge16[7:0] = data[7:0];
      if (strb[1]) merge16[15:8] = data[15:8];
   endfunction : merge16

   assign period_wr = wr_go && awaddr_q == OFS_UPDATE_PERIOD;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_control_q <= INT_CONTROL_RESET;
      end else if (wr_go && awaddr_q == OFS_INT_CONTROL) begin
         // the presence bit is hardware status, never stored
         int_control_q <= merge16(int_control_q, wdata_q, wstrb_q)
                          & ~(16'h0001 << CCLK_SEEN_BIT);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         update_period_q <= UPDATE_PERIOD_RESET;
      end else if (period_wr) begin
         update_period_q <= merge16(update_period_q, wdata_q, wstrb_q);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ev_mask_q <= EVENT_MASK_RESET;
      end else if (wr_go && awaddr_q == OFS_EVENT_MASK && wstrb_q[0]) begin
         ev_mask_q <= wdata_q[EV_WIDTH-1:0];
      end
   end

   //////////////////////////////////////////////////////////////////////
   // axi4-lite read channel, one cycle after the address is taken
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         unique case (s_axi_araddr)
            OFS_PERIODIC_POS: s_axi_rdata <= {16'h0000, periodic_pos_q};
            OFS_STROBE_POS: s_axi_rdata <= {16'h0000, strobe_pos_q};
            OFS_INT_STATUS, OFS_INT_CONTROL:
               s_axi_rdata <= {16'h0000,
                               status_word(int_control_q, cclk_seen_q)};
            OFS_UPDATE_PERIOD: s_axi_rdata <= {16'h0000, update_period_q};
            OFS_EVENT_STATUS: s_axi_rdata <= {30'h0, ev_status_q};
            OFS_EVENT_MASK: s_axi_rdata <= {30'h0, ev_mask_q};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // turn counter: wrap of the 12-bit angle steps the top two bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         angle_prev_q <= '0;
         turns_q <= 2'h0;
      end else begin
         angle_prev_q <= converter_angle;
         if (angle_prev_q[POS_BITS-1:POS_BITS-2] == 2'h3 &&
             converter_angle[POS_BITS-1:POS_BITS-2] == 2'h0) begin
            turns_q <= turns_q + 2'h1;
         end else if (angle_prev_q[POS_BITS-1:POS_BITS-2] == 2'h0 &&
                      converter_angle[POS_BITS-1:POS_BITS-2] == 2'h3) begin
            turns_q <= turns_q - 2'h1;
         end
      end
   end

   // bits 13:12 unused, angle in 11:0
   assign position = {turns_q, 2'h0, angle_prev_q};

   //////////////////////////////////////////////////////////////////////
   // periodic sampling: 500 us steps counted to the programmed period
   step_divider #(.WIDTH(20)) u_step (
      .aclk(aclk),
      .aresetn(aresetn),
      .restart(period_wr),
      .div_cycles(20'(STEP_CYC)),
      .tick(step_tick)
   );

   assign sample_tick = step_tick &&
                        (period_cnt_q + 16'h1 >= update_period_q);

   always_ff @(posedge aclk) begin
      if (!aresetn || period_wr) begin
         period_cnt_q <= 16'h0000;
      end else if (sample_tick) begin
         period_cnt_q <= 16'h0000;
      end else if (step_tick) begin
         period_cnt_q <= period_cnt_q + 16'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         periodic_pos_q <= 16'h0000;
      end else if (sample_tick) begin
         periodic_pos_q <= position;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // strobe: two-flop synchroniser then edge detect on stages 2 and 3
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strobe_s1_q <= 1'b0;
         strobe_s2_q <= 1'b0;
         strobe_s3_q <= 1'b0;
      end else begin
         strobe_s1_q <= external_strobe;
         strobe_s2_q <= strobe_s1_q;
         strobe_s3_q <= strobe_s2_q;
      end
   end

   assign strobe_rise = strobe_s2_q && !strobe_s3_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strobe_pos_q <= 16'h0000;
      end else if (strobe_rise) begin
         // same source word as the periodic sample
         strobe_pos_q <= position;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // events: set wins over write-one-to-clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ev_status_q <= '0;
      end else begin
         for (int i = 0; i < EV_WIDTH; i++) begin
            if (wr_go && awaddr_q == OFS_EVENT_STATUS && wdata_q[i]) begin
               ev_status_q[i] <= 1'b0;
            end
         end
         // flag rises on the same edge that latches the sample
         if (sample_tick && int_control_q[SAMPLE_INT_EN_BIT]) begin
            ev_status_q[EV_SAMPLE_BIT] <= 1'b1;
         end
         if (strobe_rise) begin
            ev_status_q[EV_STROBE_BIT] <= 1'b1;
         end
      end
   end

   assign irq = |(ev_status_q & ev_mask_q);

   //////////////////////////////////////////////////////////////////////
   // common clock: drive a 1 MHz square when enabled, watch its presence
   step_divider #(.WIDTH(8)) u_cclk (
      .aclk(aclk),
      .aresetn(aresetn),
      .restart(!int_control_q[CCLK_DRIVE_BIT]),
      .div_cycles(8'(CCLK_HALF)),
      .tick(cclk_tick)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn || !int_control_q[CCLK_DRIVE_BIT]) begin
         cclk_q <= 1'b0;
      end else if (cclk_tick) begin
         cclk_q <= !cclk_q;
      end
   end

   assign common_clock_out = cclk_q;
   assign common_clock_oe_n = !int_control_q[CCLK_DRIVE_BIT];

   // presence: an edge seen within four half periods
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cc_s1_q <= 1'b0;
         cc_s2_q <= 1'b0;
         cc_s3_q <= 1'b0;
         cc_idle_q <= 10'h3FF;
         cclk_seen_q <= 1'b0;
      end else begin
         cc_s1_q <= common_clock_in;
         cc_s2_q <= cc_s1_q;
         cc_s3_q <= cc_s2_q;
         if (cc_s2_q != cc_s3_q) begin
            cc_idle_q <= 10'h000;
            cclk_seen_q <= 1'b1;
         end else if (cc_idle_q < 10'(4 * CCLK_HALF)) begin
            cc_idle_q <= cc_idle_q + 10'h001;
         end else begin
            cclk_seen_q <= 1'b0;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   a_sample_latch: assert property (@(posedge aclk)
      disable iff (!aresetn)
      sample_tick |=> periodic_pos_q == $past(position))
      else $error("periodic position not latched on sample");
   a_strobe_once: assert property (@(posedge aclk)
      disable iff (!aresetn)
      strobe_rise |=> !strobe_rise)
      else $error("strobe captured twice");
   a_strobe_cap: assert property (@(posedge aclk)
      disable iff (!aresetn)
      strobe_rise |=> strobe_pos_q == $past(position))
      else $error("strobe capture wrong");
   a_pos_hold: assert property (@(posedge aclk)
      disable iff (!aresetn)
      !sample_tick |=> $stable(periodic_pos_q))
      else $error("periodic position changed without sample");
   // the square may stand one more cycle while its register clears
   a_cclk_drive: assert property (@(posedge aclk)
      disable iff (!aresetn)
      !int_control_q[CCLK_DRIVE_BIT] |-> common_clock_oe_n
      ##1 (int_control_q[CCLK_DRIVE_BIT] || !common_clock_out))
      else $error("common clock driven while disabled");
   a_irq_after: assert property (@(posedge aclk)
      disable iff (!aresetn)
      sample_tick && int_control_q[SAMPLE_INT_EN_BIT] && ev_mask_q[0]
      |=> irq && periodic_pos_q == $past(position))
      else $error("sample interrupt missing or early");
   a_step_len: assert property (@(posedge aclk)
      disable iff (!aresetn)
      step_tick |=> !step_tick [*8])
      else $error("step ticks too close");
   a_wr_ro: assert property (@(posedge aclk)
      disable iff (!aresetn)
      wr_go && awaddr_q == OFS_PERIODIC_POS |=> $stable(periodic_pos_q)
      || $past(sample_tick))
      else $error("write changed read-only position");
   c_sample: cover property (@(posedge aclk) sample_tick);
   c_strobe: cover property (@(posedge aclk) strobe_rise);
   c_irq: cover property (@(posedge aclk) $rose(irq));
   c_cclk: cover property (@(posedge aclk) !common_clock_oe_n);
endmodule : resolver_position_capture_regs
`default_nettype wire

/* File: common/resolver_pkg.sv */
// constants shared by the resolver position capture block
package resolver_pkg;
   // register indices; each register takes one aligned 32-bit word
   localparam int IDX_PERIODIC_POS = 0;
   localparam int IDX_STROBE_POS = 1;
   localparam int IDX_INT_STATUS = 2;
   localparam int IDX_INT_CONTROL = 3;
   localparam int IDX_UPDATE_PERIOD = 4;
   localparam int IDX_EVENT_STATUS = 5;
   localparam int IDX_EVENT_MASK = 6;
   localparam logic [31:0] OFS_PERIODIC_POS = 32'(IDX_PERIODIC_POS * 4);
   localparam logic [31:0] OFS_STROBE_POS = 32'(IDX_STROBE_POS * 4);
   localparam logic [31:0] OFS_INT_STATUS = 32'(IDX_INT_STATUS * 4);
   localparam logic [31:0] OFS_INT_CONTROL = 32'(IDX_INT_CONTROL * 4);
   localparam logic [31:0] OFS_UPDATE_PERIOD = 32'(IDX_UPDATE_PERIOD * 4);
   localparam logic [31:0] OFS_EVENT_STATUS = 32'(IDX_EVENT_STATUS * 4);
   localparam logic [31:0] OFS_EVENT_MASK = 32'(IDX_EVENT_MASK * 4);
   localparam int POS_BITS = 12;
   localparam int CCLK_DRIVE_BIT = 6;
   localparam int CCLK_SEEN_BIT = 15;
   localparam int SAMPLE_INT_EN_BIT = 0;
   localparam int EV_SAMPLE_BIT = 0;
   localparam int EV_STROBE_BIT = 1;
   localparam int EV_WIDTH = 2;
   localparam logic [15:0] INT_CONTROL_RESET = 16'h0000;
   localparam logic [15:0] UPDATE_PERIOD_RESET = 16'h0001;
   localparam logic [EV_WIDTH-1:0] EVENT_MASK_RESET = 2'h0;
   localparam int CLK_HZ = 200_000_000;
   localparam int PERIOD_STEP_US = 500;
   localparam int STEP_CYCLES = CLK_HZ / 1_000_000 * PERIOD_STEP_US;
   localparam int CCLK_HZ = 1_000_000;
   localparam int CCLK_HALF_CYCLES = CLK_HZ / CCLK_HZ / 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : resolver_pkg

/* File: hw/step_divider.sv */
// enable pulse divider: one pulse every div_cycles clocks
`timescale 1ns/1ps
`default_nettype none
module step_divider #(
   parameter int WIDTH = 20
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic restart,
   input wire logic [WIDTH-1:0] div_cycles,
   output logic tick
);
   logic [WIDTH-1:0] cnt_q;

   always_ff @(posedge aclk) begin
      if (!aresetn || restart) begin
         cnt_q <= '0;
      end else if (cnt_q >= div_cycles - WIDTH'(1)) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + WIDTH'(1);
      end
   end

   assign tick = aresetn && !restart && (cnt_q >= div_cycles - WIDTH'(1));
endmodule : step_divider
`default_nettype wire

/* File: dv/backplane_model.sv */
// backplane common clock line: rack clock source plus line resolution
`timescale 1ns/1ps
`default_nettype none
module backplane_model #(
   parameter int HALF = 100
) (
   input wire logic aclk,
   input wire logic src_en,
   input wire logic drv_out,
   input wire logic drv_oe_n,
   output logic line
);
   int cnt_q = 0;
   logic rack_q = 1'h0;
   always @(posedge aclk) begin
      cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
      if (cnt_q == HALF - 1)
         rack_q <= ~rack_q;
   end
   // the line is terminated low, so an undriven line shows no edges
   always_comb line = !drv_oe_n ? drv_out : (src_en & rack_q);
endmodule : backplane_model
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the resolver position capture block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import resolver_pkg::*;
   localparam int STEP = 20;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic [11:0] angle = 12'h0;
   logic strobe = 1'h0, src_en = 1'h0, cc_in, cc_out, cc_oe_n, irq;
   int miscompares = 0, samples_checked = 0, cyc = 0, turns = 0;
   always #2.5 aclk = ~aclk;
   always @(posedge aclk) cyc <= cyc + 1;
   resolver_position_capture_regs #(.STEP_CYC(STEP)) dut_u (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .converter_angle(angle), .external_strobe(strobe),
      .common_clock_in(cc_in), .common_clock_out(cc_out),
      .common_clock_oe_n(cc_oe_n), .irq(irq));
   backplane_model bp_u (.aclk(aclk), .src_en(src_en), .drv_out(cc_out),
      .drv_oe_n(cc_oe_n), .line(cc_in));
   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic hang;
      miscompares++;
      $display("ERROR %0t wait expired", $time);
      complete_run();
   endtask : hang
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      int n;
      @(posedge aclk);
      n = 0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (awready === 1'h1)
            awvalid <= 1'h0;
         if (wready === 1'h1)
            wvalid <= 1'h0;
      end while (bvalid !== 1'h1 && n < 200);
      if (n >= 200)
         hang();
      resp = bresp;
      bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [31:0] a, output logic [31:0] v);
      int n;
      @(posedge aclk);
      n = 0;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (arready === 1'h1)
            arvalid <= 1'h0;
      end while (rvalid !== 1'h1 && n < 200);
      if (n >= 200)
         hang();
      v = rdata;
      resp = rresp;
      rready <= 1'h0;
   endtask : rd
   // sel picks irq, otherwise the driven common clock
   task automatic wait_sig(input bit sel, input logic lvl, output int t);
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while ((sel ? irq : cc_out) !== lvl && n < 400);
      if (n >= 400)
         hang();
      t = cyc;
   endtask : wait_sig
   // hold long enough for several period-one samples
   task automatic settle(input logic [11:0] a);
      @(posedge aclk);
      angle <= a;
      repeat (3 * STEP) @(posedge aclk);
   endtask : settle
   function automatic logic [15:0] pos(input logic [11:0] a);
      return {turns[1:0], 2'h0, a};
   endfunction : pos
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [11:0] a;
      int t0, t1;
      void'($urandom(14472));
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      rd(OFS_INT_CONTROL, d);
      chk(d[15:0], INT_CONTROL_RESET);
      rd(OFS_UPDATE_PERIOD, d);
      chk(d[15:0], UPDATE_PERIOD_RESET);
      rd(OFS_EVENT_MASK, d);
      chk(d[1:0], EVENT_MASK_RESET);
      rd(OFS_INT_STATUS, d);
      chk(d[15:0], 16'h0);
      chk(cc_oe_n, 1'h1);
      $display("test reset done");
      wr(OFS_UPDATE_PERIOD, 32'h1);
      rd(OFS_INT_STATUS, d);
      chk(d[CCLK_SEEN_BIT], 1'h0);
      wr(OFS_INT_CONTROL, 32'h40);
      chk(resp, RESP_OKAY);
      chk(cc_oe_n, 1'h0);
      wait_sig(0, 1'h0, t0);
      wait_sig(0, 1'h1, t0);
      wait_sig(0, 1'h0, t1);
      wait_sig(0, 1'h1, t1);
      chk(t1 - t0, 2 * CCLK_HALF_CYCLES);
      rd(OFS_INT_STATUS, d);
      chk(d[15:0], 16'h8040);
      rd(OFS_INT_CONTROL, d);
      chk(d[15:0], 16'h8040);
      wr(OFS_INT_CONTROL, 32'h0);
      @(posedge aclk);
      chk(cc_oe_n, 1'h1);
      src_en <= 1'h1;
      $display("test common clock done");
      wr(OFS_PERIODIC_POS, 32'hFFFF);
      chk(resp, RESP_SLVERR);
      wr(OFS_STROBE_POS, 32'hFFFF);
      chk(resp, RESP_SLVERR);
      wr(OFS_INT_STATUS, 32'hFFFF);
      chk(resp, RESP_SLVERR);
      rd(OFS_STROBE_POS, d);
      chk(d[15:0], 16'h0);
      rd(32'h1C, d);
      chk(resp, RESP_SLVERR);
      chk(d, 32'h0);
      $display("test refusals done");
      // top bits stay 01 or 10 so no jump looks like a turn wrap
      for (int i = 0; i < 4; i++) begin
         a = 12'h400 + 12'($urandom_range(2047));
         settle(a);
         rd(OFS_PERIODIC_POS, d);
         chk(d[15:0], pos(a));
         settle(12'hFFF);
         settle(12'h000);
         turns++;
         settle(a);
         rd(OFS_PERIODIC_POS, d);
         chk(d[15:0], pos(a));
      end
      $display("test periodic done");
      rd(OFS_INT_STATUS, d);
      chk(d[15:0], 16'h8000);
      rd(OFS_INT_CONTROL, d);
      chk(d[15:0], 16'h8000);
      for (int i = 0; i < 3; i++) begin
         a = 12'h400 + 12'($urandom_range(2047));
         settle(a);
         strobe <= 1'h1;
         repeat (10) @(posedge aclk);
         rd(OFS_STROBE_POS, d);
         chk(d[15:0], pos(a));
         rd(OFS_PERIODIC_POS, d);
         chk(d[15:0], pos(a));
         angle <= a ^ 12'h0F0;
         repeat (10) @(posedge aclk);
         rd(OFS_STROBE_POS, d);
         chk(d[15:0], pos(a));
         strobe <= 1'h0;
         repeat (10) @(posedge aclk);
      end
      rd(OFS_EVENT_STATUS, d);
      chk(d[EV_STROBE_BIT], 1'h1);
      chk(irq, 1'h0);
      $display("test strobe done");
      wr(OFS_EVENT_MASK, 32'h2);
      wait_sig(1, 1'h1, t0);
      wr(OFS_EVENT_STATUS, 32'h3);
      repeat (3) @(posedge aclk);
      chk(irq, 1'h0);
      wr(OFS_UPDATE_PERIOD, 32'h3);
      wr(OFS_INT_CONTROL, 32'h1);
      wr(OFS_EVENT_MASK, 32'h1);
      wr(OFS_EVENT_STATUS, 32'h3);
      repeat (2) @(posedge aclk);
      wait_sig(1, 1'h1, t0);
      rd(OFS_PERIODIC_POS, d);
      chk(d[15:0], pos(angle));
      wr(OFS_EVENT_STATUS, 32'h1);
      repeat (2) @(posedge aclk);
      wait_sig(1, 1'h1, t1);
      chk(t1 - t0, 3 * STEP);
      $display("test interrupt done");
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
